// file: reset_watchdog_config_bits.sv
// Purpose: Power-up delay, undervoltage, watchdog and pin-route configuration bytes.
// Assumes: por_n_i marks a blank part; rst_n_i is the device reset.
// Notes:   Config bytes change only under program_enable_i.
//
// Overview of operation
// - Power-up delay enable bit is active low; 1 disables the delay.
// - Undervoltage reset enable bit: 1 turns reset on, 0 turns it off.
// - Two-bit threshold picks 2.5V, 2.7V, 4.2V or 4.5V for codes 11 to 00.
// - Postscale field in bits 3 to 1 divides by two to its value.
// - Force bit 1 runs watchdog always; 0 hands control to software enable.
// - Route bit 1 puts channel two on port C pin 1, 0 on port B pin 3.
// - Bits 7 to 4 of the watchdog configuration byte read as zero.
// - Implemented bits readable, programmable, unprogrammed 1, kept across device resets.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module reset_watchdog_config_bits
  import reset_cfg_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_CYCLES = POWERUP_DELAY_CYCLES_DEFAULT,
  parameter int unsigned WATCHDOG_BASE_CYCLES = WATCHDOG_BASE_CYCLES_DEFAULT
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   por_n_i,
  input  wire logic                   program_enable_i,
  input  wire logic                   erase_i,
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [DATA_W-1:0]      wdata_i,
  input  wire logic                   write_i,
  input  wire logic                   read_i,
  output logic      [DATA_W-1:0]      rdata_o,
  input  wire logic [LEVEL_COUNT-1:0] supply_below_i,
  output logic                        undervoltage_reset_o,
  output logic                        powerup_delay_active_o,
  output logic                        watchdog_timeout_o,
  output logic                        watchdog_running_o,
  output logic                        device_reset_request_o,
  input  wire logic                   capture_compare_channel_two_out_i,
  input  wire logic                   capture_compare_channel_two_oe_i,
  output logic                        capture_compare_channel_two_in_o,
  input  wire logic                   port_c_pin_1_gpio_out_i,
  input  wire logic                   port_c_pin_1_gpio_oe_i,
  input  wire logic                   port_b_pin_3_gpio_out_i,
  input  wire logic                   port_b_pin_3_gpio_oe_i,
  input  wire logic                   port_c_pin_1_i,
  output logic                        port_c_pin_1_o,
  output logic                        port_c_pin_1_oe_o,
  input  wire logic                   port_b_pin_3_i,
  output logic                        port_b_pin_3_o,
  output logic                        port_b_pin_3_oe_o
);

  // Config bytes.
  logic [7:0] power_reset_config_low;
  logic [7:0] watchdog_config_high;
  logic [7:0] pin_route_config_high;
  logic [7:0] next_power_reset_config_low;
  logic [7:0] next_watchdog_config_high;
  logic [7:0] next_pin_route_config_high;

  // Firmware state.
  logic       watchdog_software_enable;
  logic       next_watchdog_software_enable;
  logic       watchdog_clear;
  logic       next_watchdog_clear;
  logic       timeout_flag;
  logic       next_timeout_flag;
  logic [7:0] next_rdata;

  // Pin synchronisers.
  logic [LEVEL_COUNT-1:0] supply_meta;
  logic [LEVEL_COUNT-1:0] supply_sync;
  logic                   port_c_meta;
  logic                   port_c_sync;
  logic                   port_b_meta;
  logic                   port_b_sync;

  // Decoded fields.
  logic                   powerup_delay_enable_n;
  logic                   undervoltage_reset_enable;
  logic [THRESHOLD_W-1:0] undervoltage_threshold_select;
  logic                   watchdog_force_enable;
  logic [POSTSCALE_W-1:0] watchdog_postscale_select;
  logic                   channel_two_on_port_c;
  logic                   watchdog_run;
  logic                   timeout_pulse;
  logic                   program_write;

  assign powerup_delay_enable_n        = power_reset_config_low[POWERUP_DELAY_ENABLE_N_BIT];
  assign undervoltage_reset_enable     = power_reset_config_low[UNDERVOLTAGE_RESET_ENABLE_BIT];
  assign undervoltage_threshold_select =
    power_reset_config_low[UNDERVOLTAGE_THRESHOLD_LSB +: THRESHOLD_W];
  assign watchdog_force_enable         = watchdog_config_high[WATCHDOG_FORCE_ENABLE_BIT];
  assign watchdog_postscale_select     = watchdog_config_high[WATCHDOG_POSTSCALE_LSB +: POSTSCALE_W];
  assign channel_two_on_port_c         = pin_route_config_high[CHANNEL_TWO_ROUTE_BIT];
  assign program_write                 = write_i && program_enable_i;

  // The force bit overrides software.
  assign watchdog_run = watchdog_force_enable || watchdog_software_enable;

  // Programmer writes; erase sets every implemented bit to one.
  always_comb begin
    next_power_reset_config_low = power_reset_config_low;
    next_watchdog_config_high   = watchdog_config_high;
    next_pin_route_config_high  = pin_route_config_high;
    if (erase_i && program_enable_i) begin
      next_power_reset_config_low = POWER_RESET_CONFIG_LOW_UNPROGRAMMED;
      next_watchdog_config_high   = WATCHDOG_CONFIG_HIGH_UNPROGRAMMED;
      next_pin_route_config_high  = PIN_ROUTE_CONFIG_HIGH_UNPROGRAMMED;
    end else if (program_write) begin
      unique case (addr_i)
        POWER_RESET_CONFIG_LOW_ADDR: begin
          next_power_reset_config_low = wdata_i & POWER_RESET_CONFIG_LOW_MASK;
        end
        WATCHDOG_CONFIG_HIGH_ADDR: begin
          next_watchdog_config_high = wdata_i & WATCHDOG_CONFIG_HIGH_MASK;
        end
        PIN_ROUTE_CONFIG_HIGH_ADDR: begin
          next_pin_route_config_high = wdata_i & PIN_ROUTE_CONFIG_HIGH_MASK;
        end
        default: begin
          next_power_reset_config_low = power_reset_config_low;
        end
      endcase
    end
  end

  // Device resets leave these bytes alone.
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      power_reset_config_low <= POWER_RESET_CONFIG_LOW_UNPROGRAMMED;
      watchdog_config_high   <= WATCHDOG_CONFIG_HIGH_UNPROGRAMMED;
      pin_route_config_high  <= PIN_ROUTE_CONFIG_HIGH_UNPROGRAMMED;
    end else begin
      power_reset_config_low <= next_power_reset_config_low;
      watchdog_config_high   <= next_watchdog_config_high;
      pin_route_config_high  <= next_pin_route_config_high;
    end
  end

  // Software enable, one-shot clear, sticky timeout flag.
  always_comb begin
    next_watchdog_software_enable = watchdog_software_enable;
    next_watchdog_clear           = 1'b0;
    next_timeout_flag             = timeout_flag;
    if (write_i && addr_i == WATCHDOG_CONTROL_ADDR) begin
      next_watchdog_software_enable = wdata_i[WATCHDOG_SOFTWARE_ENABLE_BIT];
      next_watchdog_clear           = wdata_i[WATCHDOG_CLEAR_BIT];
    end
    if (write_i && addr_i == RESET_STATUS_ADDR && wdata_i[STATUS_WATCHDOG_TIMEOUT_BIT]) begin
      next_timeout_flag = 1'b0;
    end
    // Set wins over clear.
    if (timeout_pulse) begin
      next_timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_software_enable <= WATCHDOG_CONTROL_RESET[WATCHDOG_SOFTWARE_ENABLE_BIT];
      watchdog_clear           <= WATCHDOG_CONTROL_RESET[WATCHDOG_CLEAR_BIT];
      timeout_flag             <= RESET_STATUS_RESET[STATUS_WATCHDOG_TIMEOUT_BIT];
    end else begin
      watchdog_software_enable <= next_watchdog_software_enable;
      watchdog_clear           <= next_watchdog_clear;
      timeout_flag             <= next_timeout_flag;
    end
  end

  // Unmapped and unimplemented bits read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (read_i) begin
      unique case (addr_i)
        POWER_RESET_CONFIG_LOW_ADDR: begin
          next_rdata = power_reset_config_low & POWER_RESET_CONFIG_LOW_MASK;
        end
        WATCHDOG_CONFIG_HIGH_ADDR: begin
          next_rdata = watchdog_config_high & WATCHDOG_CONFIG_HIGH_MASK;
        end
        PIN_ROUTE_CONFIG_HIGH_ADDR: begin
          next_rdata = pin_route_config_high & PIN_ROUTE_CONFIG_HIGH_MASK;
        end
        WATCHDOG_CONTROL_ADDR: begin
          next_rdata[WATCHDOG_SOFTWARE_ENABLE_BIT] = watchdog_software_enable;
        end
        RESET_STATUS_ADDR: begin
          next_rdata[STATUS_WATCHDOG_TIMEOUT_BIT] = timeout_flag;
          next_rdata[STATUS_POWERUP_DELAY_BIT]    = powerup_delay_active_o;
          next_rdata[STATUS_UNDERVOLTAGE_BIT]     = undervoltage_reset_o;
          next_rdata[STATUS_WATCHDOG_RUNNING_BIT] = watchdog_run;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Two-flop pin synchronisers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_meta <= '0;
      supply_sync <= '0;
      port_c_meta <= 1'b0;
      port_c_sync <= 1'b0;
      port_b_meta <= 1'b0;
      port_b_sync <= 1'b0;
    end else begin
      supply_meta <= supply_below_i;
      supply_sync <= supply_meta;
      port_c_meta <= port_c_pin_1_i;
      port_c_sync <= port_c_meta;
      port_b_meta <= port_b_pin_3_i;
      port_b_sync <= port_b_meta;
    end
  end

  // The chosen pin carries the channel; the other keeps its port role.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_c_pin_1_o                   <= 1'b0;
      port_c_pin_1_oe_o                <= 1'b0;
      port_b_pin_3_o                   <= 1'b0;
      port_b_pin_3_oe_o                <= 1'b0;
      capture_compare_channel_two_in_o <= 1'b0;
    end else if (channel_two_on_port_c) begin
      port_c_pin_1_o                   <= capture_compare_channel_two_out_i;
      port_c_pin_1_oe_o                <= capture_compare_channel_two_oe_i;
      port_b_pin_3_o                   <= port_b_pin_3_gpio_out_i;
      port_b_pin_3_oe_o                <= port_b_pin_3_gpio_oe_i;
      capture_compare_channel_two_in_o <= port_c_sync;
    end else begin
      port_c_pin_1_o                   <= port_c_pin_1_gpio_out_i;
      port_c_pin_1_oe_o                <= port_c_pin_1_gpio_oe_i;
      port_b_pin_3_o                   <= capture_compare_channel_two_out_i;
      port_b_pin_3_oe_o                <= capture_compare_channel_two_oe_i;
      capture_compare_channel_two_in_o <= port_b_sync;
    end
  end

  watchdog_timer #(
    .BASE_CYCLES (WATCHDOG_BASE_CYCLES)
  ) u_watchdog (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (watchdog_run),
    .clear_i     (watchdog_clear),
    .postscale_i (watchdog_postscale_select),
    .timeout_o   (timeout_pulse)
  );

  supply_supervisor #(
    .DELAY_CYCLES (POWERUP_DELAY_CYCLES)
  ) u_supervisor (
    .clk_i                           (clk_i),
    .rst_n_i                         (rst_n_i),
    .undervoltage_reset_enable_i     (undervoltage_reset_enable),
    .undervoltage_threshold_select_i (undervoltage_threshold_select),
    .supply_below_i                  (supply_sync),
    .powerup_delay_enable_n_i        (powerup_delay_enable_n),
    .undervoltage_reset_o            (undervoltage_reset_o),
    .powerup_delay_active_o          (powerup_delay_active_o)
  );

  // Status and reset request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_timeout_o     <= 1'b0;
      watchdog_running_o     <= 1'b0;
      device_reset_request_o <= 1'b0;
    end else begin
      watchdog_timeout_o     <= timeout_pulse;
      watchdog_running_o     <= watchdog_run;
      device_reset_request_o <= timeout_pulse || undervoltage_reset_o || powerup_delay_active_o;
    end
  end

endmodule // reset_watchdog_config_bits
`default_nettype wire

// file: reset_cfg_pkg.sv
// Purpose: Constants for the configuration bank.
// Assumes: Byte-wide register port with 24-bit byte addresses.
// Notes:   Blank bits read 1, unimplemented bits 0.
`default_nettype none
package reset_cfg_pkg;

  localparam int ADDR_W      = 24;
  localparam int DATA_W      = 8;
  localparam int POSTSCALE_W = 3;
  localparam int THRESHOLD_W = 2;
  localparam int LEVEL_COUNT = 4;

  // Configuration byte, watchdog control and reset status addresses.
  localparam logic [23:0] POWER_RESET_CONFIG_LOW_ADDR = 24'h300002;
  localparam logic [23:0] WATCHDOG_CONFIG_HIGH_ADDR   = 24'h300003;
  localparam logic [23:0] PIN_ROUTE_CONFIG_HIGH_ADDR  = 24'h300005;
  localparam logic [23:0] WATCHDOG_CONTROL_ADDR       = 24'h000010;
  localparam logic [23:0] RESET_STATUS_ADDR           = 24'h000011;

  localparam int POWERUP_DELAY_ENABLE_N_BIT      = 0;
  localparam int UNDERVOLTAGE_RESET_ENABLE_BIT   = 1;
  localparam int UNDERVOLTAGE_THRESHOLD_LSB      = 2;
  localparam int WATCHDOG_FORCE_ENABLE_BIT       = 0;
  localparam int WATCHDOG_POSTSCALE_LSB          = 1;
  localparam int CHANNEL_TWO_ROUTE_BIT           = 0;
  localparam int WATCHDOG_SOFTWARE_ENABLE_BIT    = 0;
  localparam int WATCHDOG_CLEAR_BIT              = 1;
  localparam int STATUS_WATCHDOG_TIMEOUT_BIT     = 0;
  localparam int STATUS_POWERUP_DELAY_BIT        = 1;
  localparam int STATUS_UNDERVOLTAGE_BIT         = 2;
  localparam int STATUS_WATCHDOG_RUNNING_BIT     = 3;

  // Implemented-bit masks, blank values and control/status reset values.
  localparam logic [7:0] POWER_RESET_CONFIG_LOW_MASK = 8'h0F;
  localparam logic [7:0] WATCHDOG_CONFIG_HIGH_MASK   = 8'h0F;
  localparam logic [7:0] PIN_ROUTE_CONFIG_HIGH_MASK  = 8'h01;
  localparam logic [7:0] POWER_RESET_CONFIG_LOW_UNPROGRAMMED = 8'h0F;
  localparam logic [7:0] WATCHDOG_CONFIG_HIGH_UNPROGRAMMED   = 8'h0F;
  localparam logic [7:0] PIN_ROUTE_CONFIG_HIGH_UNPROGRAMMED  = 8'h01;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET      = 8'h00;
  localparam logic [7:0] RESET_STATUS_RESET          = 8'h00;

  // Default cycle counts.
  localparam int unsigned POWERUP_DELAY_CYCLES_DEFAULT = 32'd100000;
  localparam int unsigned WATCHDOG_BASE_CYCLES_DEFAULT = 32'd500000;

endpackage
`default_nettype wire

// file: watchdog_timer.sv
// Purpose: Watchdog base counter followed by a power-of-two postscaler.
// Assumes: Run and clear come from logic on the same clock.
// Notes:   One-cycle timeout after base period times two to the code.
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer
  import reset_cfg_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WATCHDOG_BASE_CYCLES_DEFAULT
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   run_i,
  input  wire logic                   clear_i,
  input  wire logic [POSTSCALE_W-1:0] postscale_i,
  output var  logic                   timeout_o
);

  logic [31:0] base_count;
  logic [31:0] next_base_count;
  logic [7:0]  post_count;
  logic [7:0]  next_post_count;
  logic [7:0]  post_limit;
  logic        next_timeout;

  // The last postscale count is 2**code - 1.
  assign post_limit = 8'((9'h001 << postscale_i) - 9'h001);

  always_comb begin
    next_base_count = base_count;
    next_post_count = post_count;
    next_timeout    = 1'b0;
    if (!run_i || clear_i) begin
      next_base_count = 32'h00000000;
      next_post_count = 8'h00;
    end else if (base_count == 32'(BASE_CYCLES - 1)) begin
      next_base_count = 32'h00000000;
      if (post_count == post_limit) begin
        next_post_count = 8'h00;
        next_timeout    = 1'b1;
      end else begin
        next_post_count = post_count + 8'h01;
      end
    end else begin
      next_base_count = base_count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_count <= 32'h00000000;
      post_count <= 8'h00;
      timeout_o  <= 1'b0;
    end else begin
      base_count <= next_base_count;
      post_count <= next_post_count;
      timeout_o  <= next_timeout;
    end
  end

endmodule // watchdog_timer
`default_nettype wire

// file: supply_supervisor.sv
// Purpose: Undervoltage reset and power-up delay sequencing.
// Assumes: Comparator levels are already synchronised to clk_i.
// Notes:   Leaving reset or an undervoltage hold runs the delay when it is enabled.
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor
  import reset_cfg_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = POWERUP_DELAY_CYCLES_DEFAULT
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   undervoltage_reset_enable_i,
  input  wire logic [THRESHOLD_W-1:0] undervoltage_threshold_select_i,
  input  wire logic [LEVEL_COUNT-1:0] supply_below_i,
  input  wire logic                   powerup_delay_enable_n_i,
  output var  logic                   undervoltage_reset_o,
  output var  logic                   powerup_delay_active_o
);

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } supervisor_state_e;

  supervisor_state_e state;
  supervisor_state_e next_state;
  logic [31:0]       delay_count;
  logic [31:0]       next_delay_count;
  logic              below;
  supervisor_state_e release_state;

  // Trip when enabled and the selected below level reads high.
  assign below = undervoltage_reset_enable_i && supply_below_i[undervoltage_threshold_select_i];
  // Active low: 0 runs the delay.
  assign release_state = powerup_delay_enable_n_i ? ST_RUN : ST_DELAY;

  always_comb begin
    next_state       = state;
    next_delay_count = 32'h00000000;
    unique case (state)
      ST_HOLD: begin
        if (!below) begin
          next_state = release_state;
        end
      end
      ST_DELAY: begin
        if (below) begin
          next_state = ST_HOLD;
        end else if (delay_count == 32'(DELAY_CYCLES - 1)) begin
          next_state = ST_RUN;
        end else begin
          next_delay_count = delay_count + 32'h00000001;
        end
      end
      ST_RUN: begin
        if (below) begin
          next_state = ST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                  <= ST_HOLD;
      delay_count            <= 32'h00000000;
      undervoltage_reset_o   <= 1'b0;
      powerup_delay_active_o <= 1'b0;
    end else begin
      state                  <= next_state;
      delay_count            <= next_delay_count;
      undervoltage_reset_o   <= below;
      powerup_delay_active_o <= (next_state == ST_DELAY);
    end
  end

endmodule // supply_supervisor
`default_nettype wire

// file: pin_board.sv
// Purpose: Board side of the two routed pins.
// Assumes: The block drives a pin only while its enable is high.
// Notes:   An undriven pin follows the board source given by the bench.
`timescale 1ns/1ns
`default_nettype none
module pin_board (
  input  wire logic c_oe_i,
  input  wire logic c_drv_i,
  input  wire logic b_oe_i,
  input  wire logic b_drv_i,
  input  wire logic c_ext_i,
  input  wire logic b_ext_i,
  output var  logic c_pin_o,
  output var  logic b_pin_o
);
  assign c_pin_o = c_oe_i ? c_drv_i : c_ext_i;
  assign b_pin_o = b_oe_i ? b_drv_i : b_ext_i;
endmodule // pin_board
`default_nettype wire

// file: reset_watchdog_config_bits_monitor.sv
// Purpose: Port assertions for the configuration bank.
// Assumes: Strobes last one cycle.
// Notes:   Shadow copies of two bytes follow programmer writes.
`timescale 1ns/1ns
`default_nettype none
module reset_watchdog_config_bits_monitor
  import reset_cfg_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_CYCLES = 8,
  parameter int unsigned WATCHDOG_BASE_CYCLES = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        por_n_i,
  input wire logic        program_enable_i,
  input wire logic        erase_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        undervoltage_reset_o,
  input wire logic        powerup_delay_active_o,
  input wire logic        watchdog_timeout_o,
  input wire logic        watchdog_running_o,
  input wire logic        device_reset_request_o
);
  logic [7:0] cfg_low;
  logic [7:0] cfg_high;
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      cfg_low  <= 8'h0F;
      cfg_high <= 8'h0F;
    end else if (program_enable_i && erase_i) begin
      cfg_low  <= 8'h0F;
      cfg_high <= 8'h0F;
    end else if (program_enable_i && write_i) begin
      if (addr_i == POWER_RESET_CONFIG_LOW_ADDR) cfg_low <= wdata_i & 8'h0F;
      if (addr_i == WATCHDOG_CONFIG_HIGH_ADDR) cfg_high <= wdata_i & 8'h0F;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rdata_idle: assert property (!read_i |=> rdata_o == 8'h00) else $error("read data not idle");
  chk_upper_zero: assert property (read_i && addr_i == WATCHDOG_CONFIG_HIGH_ADDR |=> rdata_o[7:4] == 4'h0)
    else $error("upper bits not zero");
  chk_low_readback: assert property (read_i && addr_i == POWER_RESET_CONFIG_LOW_ADDR |=> rdata_o == $past(cfg_low))
    else $error("low byte readback wrong");
  chk_force_runs: assert property ((rst_n_i && cfg_high[0]) [*3] |-> watchdog_running_o) else $error("forced watchdog idle");
  chk_uv_off: assert property (!cfg_low[1] [*4] |-> !undervoltage_reset_o) else $error("disabled trip fired");
  chk_no_delay: assert property (!$past(rst_n_i) && cfg_low[0] |-> !powerup_delay_active_o [*4])
    else $error("delay ran while off");
  chk_delay_runs: assert property (!$past(rst_n_i) && !cfg_low[0] && !cfg_low[1] |=> powerup_delay_active_o [*7])
    else $error("delay missing");
  chk_pulse_req: assert property (watchdog_timeout_o |-> device_reset_request_o ##1 !watchdog_timeout_o)
    else $error("timeout pulse wrong");
  chk_delay_req: assert property (powerup_delay_active_o |=> device_reset_request_o) else $error("no request");
  cover property (watchdog_timeout_o);
  cover property (undervoltage_reset_o);
  cover property (powerup_delay_active_o);
endmodule // reset_watchdog_config_bits_monitor
bind reset_watchdog_config_bits reset_watchdog_config_bits_monitor #(
  .POWERUP_DELAY_CYCLES(POWERUP_DELAY_CYCLES),
  .WATCHDOG_BASE_CYCLES(WATCHDOG_BASE_CYCLES)
) i_monitor (.*);
`default_nettype wire

// file: tb_reset_watchdog_config_bits.sv
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Short delay and watchdog counts.
// Notes:   Random data comes from a fixed xorshift seed.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %h seen %h", n, e, g); end end
module tb_reset_watchdog_config_bits;
  import reset_cfg_pkg::*;
  localparam int DLY = 8;
  localparam int BASE = 4;
  logic clk_i = 0, rst_n_i = 0, por_n_i = 0, program_enable_i = 0, erase_i = 0, write_i = 0, read_i = 0;
  logic [23:0] addr_i = '0;
  logic [7:0]  wdata_i = '0;
  logic [3:0]  supply_below_i = '0;
  logic        cc_out = 0, cc_oe = 0, c_ext = 0, b_ext = 0;
  logic [7:0]  rdata_o, d;
  logic        uv, dly, wto, wrun, cc_in, pc_i, pc_o, pc_oe, pb_i, pb_o, pb_oe;
  int          n_errors = 0, cmp_count = 0, cyc = 0, k, n;
  logic [31:0] rs = 32'd62849;
  logic [23:0] cfg_a [3] = '{POWER_RESET_CONFIG_LOW_ADDR, WATCHDOG_CONFIG_HIGH_ADDR, PIN_ROUTE_CONFIG_HIGH_ADDR};
  always #4 clk_i = ~clk_i;
  reset_watchdog_config_bits #(.POWERUP_DELAY_CYCLES(DLY), .WATCHDOG_BASE_CYCLES(BASE)) i_reset_watchdog_config_bits (
    .*,
    .undervoltage_reset_o(uv), .powerup_delay_active_o(dly), .watchdog_timeout_o(wto),
    .watchdog_running_o(wrun), .device_reset_request_o(), .capture_compare_channel_two_out_i(cc_out),
    .capture_compare_channel_two_oe_i(cc_oe), .capture_compare_channel_two_in_o(cc_in),
    .port_c_pin_1_gpio_out_i(1'b0), .port_c_pin_1_gpio_oe_i(1'b0), .port_b_pin_3_gpio_out_i(1'b0),
    .port_b_pin_3_gpio_oe_i(1'b0), .port_c_pin_1_i(pc_i), .port_c_pin_1_o(pc_o), .port_c_pin_1_oe_o(pc_oe),
    .port_b_pin_3_i(pb_i), .port_b_pin_3_o(pb_o), .port_b_pin_3_oe_o(pb_oe));
  pin_board i_pin_board (.c_oe_i(pc_oe), .c_drv_i(pc_o), .b_oe_i(pb_oe), .b_drv_i(pb_o), .c_ext_i(c_ext),
    .b_ext_i(b_ext), .c_pin_o(pc_i), .b_pin_o(pb_i));
  function automatic logic [7:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function automatic logic [7:0] cfg_exp(input logic [23:0] a, input logic [7:0] v);
    return v & ((a == PIN_ROUTE_CONFIG_HIGH_ADDR) ? 8'h01 : 8'h0F);
  endfunction
  task automatic wr(input logic [23:0] a, input logic [7:0] v);
    @(posedge clk_i);
    write_i <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e, input string s);
    @(posedge clk_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    read_i <= 1'b0;
    @(negedge clk_i);
    `CHK(s, e, rdata_o)
  endtask
  task automatic note(input string s);
    $display("test %s done, mismatches so far %0d", s, n_errors);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    for (k = 0; k < 3; k++) rd(cfg_a[k], cfg_exp(cfg_a[k], 8'hFF), "blank");
    rd(24'h300004, 8'h00, "unmapped");
    `CHK("delay off", 1'b0, dly)
    note("blank");
    @(posedge clk_i) program_enable_i <= 1'b1;
    for (k = 0; k < 12; k++) begin
      d = xs();
      wr(cfg_a[k % 3], d);
      rd(cfg_a[k % 3], cfg_exp(cfg_a[k % 3], d), "program");
    end
    wr(PIN_ROUTE_CONFIG_HIGH_ADDR, 8'h00);
    @(posedge clk_i) program_enable_i <= 1'b0;
    wr(PIN_ROUTE_CONFIG_HIGH_ADDR, 8'h01);
    rd(PIN_ROUTE_CONFIG_HIGH_ADDR, 8'h00, "locked");
    @(posedge clk_i) program_enable_i <= 1'b1;
    note("program");
    for (k = 0; k < 2; k++) begin
      wr(PIN_ROUTE_CONFIG_HIGH_ADDR, 8'(k));
      @(posedge clk_i) cc_oe <= 1'b1;
      cc_out <= xs() > 8'h7F;
      repeat (3) @(negedge clk_i);
      `CHK("c drive", k[0], pc_oe)
      `CHK("b drive", ~k[0], pb_oe)
      `CHK("pin level", cc_out, k[0] ? pc_o : pb_o)
      @(posedge clk_i) cc_oe <= 1'b0;
      c_ext <= 1'b1;
      b_ext <= 1'b0;
      repeat (5) @(negedge clk_i);
      `CHK("channel in", k[0], cc_in)
    end
    note("route");
    for (k = 0; k < 4; k++) begin
      wr(POWER_RESET_CONFIG_LOW_ADDR, 8'(k << 2) | 8'h03);
      @(posedge clk_i) supply_below_i <= 4'(1 << k);
      repeat (6) @(negedge clk_i);
      `CHK("trip", 1'b1, uv)
      @(posedge clk_i) supply_below_i <= ~4'(1 << k);
      repeat (6) @(negedge clk_i);
      `CHK("no trip", 1'b0, uv)
    end
    wr(POWER_RESET_CONFIG_LOW_ADDR, 8'h01);
    repeat (6) @(negedge clk_i);
    `CHK("trip off", 1'b0, uv)
    @(posedge clk_i) supply_below_i <= 4'h0;
    note("undervoltage");
    wr(POWER_RESET_CONFIG_LOW_ADDR, 8'h0C);
    @(posedge clk_i) rst_n_i <= 1'b0;
    @(posedge clk_i) rst_n_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("delay on", 1'b1, dly)
    repeat (DLY + 3) @(negedge clk_i);
    `CHK("delay end", 1'b0, dly)
    rd(POWER_RESET_CONFIG_LOW_ADDR, 8'h0C, "kept");
    note("delay");
    for (k = 0; k < 8; k++) begin
      wr(WATCHDOG_CONFIG_HIGH_ADDR, 8'(k << 1) | 8'h01);
      wr(WATCHDOG_CONTROL_ADDR, 8'h02);
      repeat (3) @(negedge clk_i);
      n = 0;
      while (wto !== 1'b1 && n < 2000) begin
        @(negedge clk_i);
        n++;
      end
      `CHK("period", 1'b1, n >= (BASE << k) - 1 && n <= (BASE << k) + 4)
      `CHK("forced", 1'b1, wrun)
    end
    rd(RESET_STATUS_ADDR, 8'h09, "status");
    wr(WATCHDOG_CONFIG_HIGH_ADDR, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr(WATCHDOG_CONTROL_ADDR, 8'(k));
      repeat (3) @(negedge clk_i);
      `CHK("software run", k[0], wrun)
    end
    note("watchdog");
    @(posedge clk_i) erase_i <= 1'b1;
    @(posedge clk_i) erase_i <= 1'b0;
    rd(WATCHDOG_CONFIG_HIGH_ADDR, 8'h0F, "erased");
    note("erase");
    close_out();
  end
endmodule // tb_reset_watchdog_config_bits
`default_nettype wire
